// File: card_cfg.v
// host decode, jumper routing, d/a latches and pacer timers
// What this block does
// - respond to sixteen addresses from base only
// - switch positions 1..5 give A8..A4, on=0
// - require A9 high, low nibble selects location
// - factory switch state decodes base 220
// - per channel 12-bit first-rank input latch
// - double-buffered: second rank updates both together
// - transparent jumper: write reaches converter at once
// - dma request on jumper-chosen channel 5,6,7
// - interrupt on jumper-chosen line, default 15
// - three 16-bit down-counting timers, timer 1 chained to timer 2
// - timer 2 clocked from 2 MHz reference
// - timer 1 clocked by timer 2 output
// - timer 0 clock: internal 2 MHz or external
// - input mux 16 single-ended or 8 differential
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "card_cfg_defs.vh"
module card_cfg (
   // clock, reset, enable
   input wire mclk,
   input wire rst_b,
   input wire ce,
   // host io cycle
   input wire [9:0] host_addr,
   input wire host_ior_b,
   input wire host_iow_b,
   input wire [15:0] host_data,
   // board switch and jumpers (on = 0)
   input wire [4:0] base_select_switch,
   input wire dac_latch_mode_jumper,
   input wire [7:0] irq_line_jumper,
   input wire dma_select_jumper_a,
   input wire dma_select_jumper_b,
   input wire input_config_jumper,
   input wire timer0_internal_clock_sel,
   input wire timer0_external_clock_sel,
   input wire external_timer_clock_in,
   // internal requests
   input wire irq_event,
   input wire dma_event,
   // decode outputs
   output reg card_sel_q,
   output reg [3:0] reg_index_q,
   // dma and interrupt lines (index 0..2 = channel 5..7)
   output reg [2:0] dma_req_q,
   output reg [7:0] irq_line_q,
   // converter latches
   output reg [11:0] dac0_code_q,
   output reg [11:0] dac1_code_q,
   // timers
   output reg [2:0] timer_out_q,
   output reg differential_mode_q,
   // axi4-lite slave
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire [4:0] base_bits; // expected A8..A4
   wire hit; // io cycle inside our window
   wire host_wr; // write io cycle
   reg host_wr_q; // previous write state for edge detect
   wire wr_edge; // one cycle at write start
   // switch position 1 is A8; a closed position reads 0
   assign base_bits = base_select_switch;
   // A9 fixed high, A3..A0 free so window is 16 locations
   assign hit = (host_addr[9] == `A9_REQUIRED) && (host_addr[8:4] == base_bits)
                && (!host_ior_b || !host_iow_b);
   assign host_wr = hit && !host_iow_b;
   assign wr_edge = host_wr && !host_wr_q;
   // registered select and location index
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         card_sel_q <= 1'b0;
         reg_index_q <= 4'h0;
         host_wr_q <= 1'b0;
      end else if (ce) begin
         card_sel_q <= hit;
         reg_index_q <= hit ? host_addr[3:0] : 4'h0;
         host_wr_q <= host_wr;
      end
   end
   // ----------------------------------------------------------------
   // d/a two-rank latches
   // ----------------------------------------------------------------
   reg [11:0] dac0_in_q; // first rank, channel 1
   reg [11:0] dac1_in_q; // first rank, channel 2
   wire dac0_wr; // host write to d/a channel 1
   wire dac1_wr; // host write to d/a channel 2
   wire sw_load; // software second-rank transfer
   assign dac0_wr = wr_edge && (host_addr[3:0] == 4'h4);
   assign dac1_wr = wr_edge && (host_addr[3:0] == 4'h6);
   // first rank captures the host data bus
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dac0_in_q <= `DAC_RESET;
         dac1_in_q <= `DAC_RESET;
      end else if (ce) begin
         if (dac0_wr) begin
            dac0_in_q <= host_data[11:0];
         end
         if (dac1_wr) begin
            dac1_in_q <= host_data[11:0];
         end
      end
   end
   // second rank: jumper high = transparent, low = double buffered
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dac0_code_q <= `DAC_RESET;
         dac1_code_q <= `DAC_RESET;
      end else if (ce) begin
         if (dac_latch_mode_jumper) begin
            // transparent: straight from the bus, no wait for transfer
            if (dac0_wr) begin
               dac0_code_q <= host_data[11:0];
            end
            if (dac1_wr) begin
               dac1_code_q <= host_data[11:0];
            end
         end else if (sw_load) begin
            // both outputs move on the same edge
            dac0_code_q <= dac0_in_q;
            dac1_code_q <= dac1_in_q;
         end
      end
   end
   // ----------------------------------------------------------------
   // dma and interrupt routing
   // ----------------------------------------------------------------
   // jumper code a,b: 00 -> ch5, 01 -> ch6, 1x -> ch7
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dma_req_q <= 3'h0;
         irq_line_q <= 8'h00;
         differential_mode_q <= 1'b0;
      end else if (ce) begin
         dma_req_q[0] <= dma_event && !dma_select_jumper_a && !dma_select_jumper_b;
         dma_req_q[1] <= dma_event && !dma_select_jumper_a && dma_select_jumper_b;
         dma_req_q[2] <= dma_event && dma_select_jumper_a;
         // one-hot jumper row; bit 7 is level 15, the factory row
         irq_line_q <= irq_event ? irq_line_jumper : 8'h00;
         differential_mode_q <= input_config_jumper;
      end
   end
   // ----------------------------------------------------------------
   // reference divider and timers
   // ----------------------------------------------------------------
   reg [3:0] div_q; // divides mclk to the 2 MHz reference tick
   wire ref_tick;
   reg ext_q; // external clock previous level
   wire ext_tick;
   wire t0_tick;
   wire [2:0] t_en;
   wire [2:0] t_tick;
   wire [2:0] t_pulse;
   wire [15:0] t_count [0:2];
   reg [31:0] ctrl_q; // software control word
   reg [15:0] reload_q [0:2]; // per-timer reload values
   reg [2:0] reload_wr; // reload strobes
   // last divider state; the division ratio must stay within sixteen
   localparam integer ref_last = `REF_DIV - 1;
   assign ref_tick = (div_q == ref_last[3:0]);
   assign ext_tick = external_timer_clock_in && !ext_q;
   // the two select jumpers are exclusive; internal wins if both
   assign t0_tick = timer0_internal_clock_sel ? ref_tick :
                    (timer0_external_clock_sel ? ext_tick : 1'b0);
   assign t_en = {ctrl_q[`CTRL_T2_EN_BIT], ctrl_q[`CTRL_T1_EN_BIT], ctrl_q[`CTRL_T0_EN_BIT]};
   assign t_tick[0] = t0_tick && t_en[0];
   assign t_tick[1] = t_pulse[2] && t_en[1];
   assign t_tick[2] = ref_tick && t_en[2];
   assign sw_load = ctrl_q[`CTRL_LOAD_BIT];
   // reference divider and external edge detect
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= 4'h0;
         ext_q <= 1'b0;
         timer_out_q <= 3'h0;
      end else if (ce) begin
         div_q <= ref_tick ? 4'h0 : div_q + 4'h1;
         ext_q <= external_timer_clock_in;
         timer_out_q <= t_pulse;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_tmr
         // each channel is a 16-bit down counter; channel 1 counts channel 2 pulses
         down_timer u_tmr (
            .mclk(mclk),
            .rst_b(rst_b),
            .ce(ce),
            .tick(t_tick[gi]),
            .load(reload_wr[gi]),
            .reload(reload_q[gi]),
            .count_q(t_count[gi]),
            .out_q(t_pulse[gi])
         );
      end
   endgenerate
   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   // offsets: 0 ctrl, 4 status, 8 reload t0, c reload t1/t2
   reg [3:0] aw_q; // latched write address
   reg aw_have_q; // address taken
   reg [31:0] w_q; // latched write data
   reg w_have_q; // data taken
   wire do_wr;
   assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
   // write channel: address and data may arrive in either order
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         aw_q <= 4'h0;
         aw_have_q <= 1'b0;
         w_q <= 32'h0;
         w_have_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         ctrl_q <= 32'h0;
         reload_q[0] <= `TMR_RESET;
         reload_q[1] <= `TMR_RESET;
         reload_q[2] <= `TMR_RESET;
         reload_wr <= 3'h0;
      end else if (ce) begin
         reload_wr <= 3'h0;
         ctrl_q[`CTRL_LOAD_BIT] <= 1'b0; // load is a self-clearing pulse
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= s_axi_wdata;
            w_have_q <= 1'b1;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (aw_q)
               `OFF_CTRL: begin
                  ctrl_q <= w_q;
               end
               `OFF_DAC0: begin
                  reload_q[0] <= w_q[15:0];
                  reload_wr[0] <= 1'b1;
               end
               `OFF_DAC1: begin
                  reload_q[1] <= w_q[15:0];
                  reload_q[2] <= w_q[31:16];
                  reload_wr[1] <= 1'b1;
                  reload_wr[2] <= 1'b1;
               end
               `OFF_STATUS: begin
                  s_axi_bresp <= 2'h2; // read-only
               end
               default: begin
                  s_axi_bresp <= 2'h2; // unmapped
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // read channel: one read at a time, answer one cycle after accept
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (ce) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `OFF_CTRL: begin
                  s_axi_rdata <= ctrl_q;
               end
               `OFF_STATUS: begin
                  s_axi_rdata <= {8'h00, dac1_code_q, dac0_code_q};
               end
               `OFF_DAC0: begin
                  s_axi_rdata <= {16'h0, t_count[0]};
               end
               `OFF_DAC1: begin
                  s_axi_rdata <= {t_count[2], t_count[1]};
               end
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // card_cfg

// File: card_cfg_defs.vh
// constants for the card decode and configuration block
`ifndef CARD_CFG_DEFS_VH
`define CARD_CFG_DEFS_VH
// ----------------------------------------------------------------
// register byte offsets on the register bus
// ----------------------------------------------------------------
`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h4
`define OFF_DAC0 4'h8
`define OFF_DAC1 4'hc
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_LOAD_BIT 0
`define CTRL_T0_EN_BIT 1
`define CTRL_T1_EN_BIT 2
`define CTRL_T2_EN_BIT 3
// ----------------------------------------------------------------
// decode constants and reset values
// ----------------------------------------------------------------
`define WINDOW_SIZE 16
`define A9_REQUIRED 1'b1
`define DEFAULT_SWITCH 5'h02
`define DAC_RESET 12'h000
`define TMR_RESET 16'hffff
// ----------------------------------------------------------------
// timing: mclk 20 MHz, reference 2 MHz
// ----------------------------------------------------------------
`define MCLK_HZ 20000000
`define REF_HZ 2000000
`define REF_DIV (`MCLK_HZ / `REF_HZ)
`endif

// File: down_timer.v
// one 16-bit down-counting timer channel
`timescale 1ns/100ps
module down_timer (
   // clock and reset
   input wire mclk,
   input wire rst_b,
   input wire ce,
   // control
   input wire tick,
   input wire load,
   input wire [15:0] reload,
   // status
   output reg [15:0] count_q,
   output reg out_q
);
   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   // counts down on each tick, pulses out and reloads on the tick taken at count one
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= 16'hffff;
         out_q <= 1'b0;
      end else if (ce) begin
         out_q <= 1'b0;
         if (load) begin
            count_q <= reload;
         end else if (tick) begin
            if (count_q <= 16'h0001) begin
               // terminal count: reload and emit one pulse
               count_q <= reload;
               out_q <= 1'b1;
            end else begin
               count_q <= count_q - 16'h0001;
            end
         end
      end
   end
endmodule // down_timer

// File: card_cfg_checker.sv
// concurrent checks on decode, routing and latch timing of card_cfg
`timescale 1ns/100ps
module card_cfg_checker (
   // clock and reset
   input wire mclk,
   input wire rst_b,
   input wire ce,
   // host and board inputs
   input wire [9:0] host_addr,
   input wire host_ior_b,
   input wire host_iow_b,
   input wire [15:0] host_data,
   input wire [4:0] base_select_switch,
   input wire dac_latch_mode_jumper,
   input wire [7:0] irq_line_jumper,
   input wire dma_select_jumper_a,
   input wire dma_select_jumper_b,
   input wire input_config_jumper,
   input wire irq_event,
   input wire dma_event,
   // observed outputs
   input wire card_sel_q,
   input wire [3:0] reg_index_q,
   input wire [2:0] dma_req_q,
   input wire [7:0] irq_line_q,
   input wire [11:0] dac0_code_q,
   input wire differential_mode_q
);
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // an io cycle inside the switch-selected window
   wire hit = ce && !(host_ior_b && host_iow_b) && host_addr[9] && host_addr[8:4] == base_select_switch;
   // channel 7 wins when jumper a is set
   wire [2:0] dma_exp = !dma_event ? 3'h0 : dma_select_jumper_a ? 3'h4 : dma_select_jumper_b ? 3'h2 : 3'h1;
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   a_sel_on_match: assert property (hit |=> card_sel_q)
      else $error("card select missing on window hit");
   a_sel_no_miss: assert property (ce && !hit |=> !card_sel_q)
      else $error("card select outside window");
   a_index_pass: assert property (hit |=> reg_index_q == $past(host_addr[3:0]))
      else $error("register index differs from low nibble");
   a_dma_route: assert property (ce |=> dma_req_q == $past(dma_exp))
      else $error("dma request on wrong channel");
   a_irq_route: assert property (ce |=> irq_line_q == ($past(irq_event) ? $past(irq_line_jumper) : 8'h00))
      else $error("interrupt on wrong line");
   a_dac_direct: assert property (hit && $fell(host_iow_b) && dac_latch_mode_jumper && host_addr[3:0] == 4'h4
      |=> dac0_code_q == $past(host_data[11:0]))
      else $error("transparent write did not reach converter");
   a_dac_held: assert property (!dac_latch_mode_jumper && !host_iow_b |=> $stable(dac0_code_q))
      else $error("double buffered converter changed on host write");
   a_diff_mirror: assert property (ce |=> differential_mode_q == $past(input_config_jumper))
      else $error("input configuration not mirrored");
endmodule // card_cfg_checker

bind card_cfg card_cfg_checker chk (.mclk, .rst_b, .ce, .host_addr, .host_ior_b, .host_iow_b, .host_data,
   .base_select_switch, .dac_latch_mode_jumper, .irq_line_jumper, .dma_select_jumper_a, .dma_select_jumper_b,
   .input_config_jumper, .irq_event, .dma_event, .card_sel_q, .reg_index_q, .dma_req_q, .irq_line_q,
   .dac0_code_q, .differential_mode_q);

// File: host_isa_model.sv
// behavioural host io bus driving the card's decode inputs
`timescale 1ns/100ps
module host_isa_model (
   // clock
   input wire mclk,
   // card answer
   input wire card_sel_q,
   input wire [3:0] reg_index_q,
   // host io cycle
   output reg [9:0] host_addr,
   output reg host_ior_b,
   output reg host_iow_b,
   output reg [15:0] host_data
);
   // idle bus: strobes high, lines hold a junk pattern
   initial begin
      host_addr = 10'h155;
      host_ior_b = 1'b1;
      host_iow_b = 1'b1;
      host_data = 16'h5a5a;
   end
   // one io cycle of three clocks; select sampled while the strobe stands
   task io_cycle(input logic wr, input logic [9:0] a, input logic [15:0] d, output logic sel, output logic [3:0] idx);
      @(posedge mclk);
      host_addr <= a;
      host_data <= d;
      if (wr) host_iow_b <= 1'b0;
      else host_ior_b <= 1'b0;
      repeat (2) @(posedge mclk);
      sel = card_sel_q;
      idx = reg_index_q;
      host_iow_b <= 1'b1;
      host_ior_b <= 1'b1;
      @(posedge mclk);
      // released bus shows the inverse, so stale values cannot pass
      host_addr <= ~a;
      host_data <= ~d;
   endtask
endmodule // host_isa_model

// File: tb_card_cfg.sv
// self-checking bench for card_cfg
`timescale 1ns/100ps
`include "card_cfg_defs.vh"
module tb_card_cfg;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic mclk, rst_b, ce, host_ior_b, host_iow_b, sel, card_sel_q, differential_mode_q;
   logic dac_latch_mode_jumper, dma_select_jumper_a, dma_select_jumper_b, input_config_jumper;
   logic timer0_internal_clock_sel, timer0_external_clock_sel, external_timer_clock_in, irq_event, dma_event;
   logic [9:0] host_addr;
   logic [15:0] host_data;
   logic [4:0] base_select_switch;
   logic [7:0] irq_line_jumper, irq_line_q;
   logic [3:0] idx, reg_index_q, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [2:0] dma_req_q, timer_out_q;
   logic [11:0] dac0_code_q, dac1_code_q;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_run;
   int failures, tests_run, cyc, t1, t2;
   host_isa_model host (.mclk(mclk), .card_sel_q(card_sel_q), .reg_index_q(reg_index_q), .host_addr(host_addr),
      .host_ior_b(host_ior_b), .host_iow_b(host_iow_b), .host_data(host_data));
   card_cfg DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce), .host_addr(host_addr), .host_ior_b(host_ior_b),
      .host_iow_b(host_iow_b), .host_data(host_data), .base_select_switch(base_select_switch),
      .dac_latch_mode_jumper(dac_latch_mode_jumper), .irq_line_jumper(irq_line_jumper),
      .dma_select_jumper_a(dma_select_jumper_a), .dma_select_jumper_b(dma_select_jumper_b),
      .input_config_jumper(input_config_jumper), .timer0_internal_clock_sel(timer0_internal_clock_sel),
      .timer0_external_clock_sel(timer0_external_clock_sel), .external_timer_clock_in(external_timer_clock_in),
      .irq_event(irq_event), .dma_event(dma_event), .card_sel_q(card_sel_q), .reg_index_q(reg_index_q),
      .dma_req_q(dma_req_q), .irq_line_q(irq_line_q), .dac0_code_q(dac0_code_q), .dac1_code_q(dac1_code_q),
      .timer_out_q(timer_out_q), .differential_mode_q(differential_mode_q), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   // ---------------------------------------------
   // clock, cycle count, external timer clock (runs only in its test)
   // ---------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (ext_run && cyc % 4 == 0) external_timer_clock_in <= ~external_timer_clock_in;
   end
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // write: both channels offered together, each released when taken
   task axi_write(input logic [3:0] a, input logic [31:0] d);
      logic aw, w;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
         @(posedge mclk);
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge mclk);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task axi_read(input logic [3:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge mclk);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // spacing between two terminal pulses of one timer, in mclk cycles
   task meas(input int i, input int exp);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin @(posedge mclk); n++; end while (timer_out_q[i] !== 1'b1 && n < 2000);
         t1 = t2;
         t2 = cyc;
      end
      chk("timer pulse spacing", 32'(exp), 32'(t2 - t1));
   endtask
   // ---------------------------------------------
   // watchdog: far beyond the expected run of a few hundred cycles
   // ---------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      results;
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {rst_b, dac_latch_mode_jumper, dma_select_jumper_a, dma_select_jumper_b, input_config_jumper} = 5'h00;
      {timer0_external_clock_sel, external_timer_clock_in, irq_event, dma_event, ext_run} = 5'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {ce, timer0_internal_clock_sel, s_axi_wstrb} = 6'h3f;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, failures, tests_run, cyc, t2} = 0;
      base_select_switch = 5'h02;
      irq_line_jumper = 8'h80;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      axi_read(`OFF_CTRL);
      chk("ctrl after reset", 32'h0, rd);
      // double buffered: first rank only, then a load moves both
      host.io_cycle(1'b1, 10'h224, 16'h0123, sel, idx);
      chk("select", 32'h1, 32'(sel));
      chk("index", 32'h4, 32'(idx));
      host.io_cycle(1'b1, 10'h226, 16'h0456, sel, idx);
      chk("dac1 before load", 32'h0, 32'(dac1_code_q));
      axi_write(`OFF_CTRL, 32'h1);
      axi_read(`OFF_STATUS);
      chk("status after load", 32'h00456123, rd);
      chk("dac0 after load", 32'h123, 32'(dac0_code_q));
      axi_write(`OFF_STATUS, 32'h1);
      chk("status write response", 32'h2, 32'(rr));
      axi_read(4'h1);
      chk("unmapped read response", 32'h2, 32'(rr));
      chk("unmapped read data", 32'h0, rd);
      // transparent mode and refused addresses
      dac_latch_mode_jumper <= 1'b1;
      host.io_cycle(1'b1, 10'h226, 16'h0def, sel, idx);
      chk("dac1 transparent", 32'hdef, 32'(dac1_code_q));
      host.io_cycle(1'b1, 10'h224, 16'h0abc, sel, idx);
      chk("dac0 transparent", 32'habc, 32'(dac0_code_q));
      // clock enable low: a matching write must leave every state alone
      ce <= 1'b0;
      host.io_cycle(1'b1, 10'h224, 16'h0777, sel, idx);
      chk("select frozen", 32'h0, 32'(sel));
      chk("dac0 frozen", 32'habc, 32'(dac0_code_q));
      ce <= 1'b1;
      host.io_cycle(1'b1, 10'h326, 16'h0111, sel, idx);
      chk("select other base", 32'h0, 32'(sel));
      host.io_cycle(1'b1, 10'h026, 16'h0222, sel, idx);
      chk("dac1 after misses", 32'hdef, 32'(dac1_code_q));
      host.io_cycle(1'b0, 10'h22f, 16'h0, sel, idx);
      chk("index top", 32'hf, 32'(idx));
      base_select_switch <= 5'h1f;
      host.io_cycle(1'b0, 10'h3f9, 16'h0, sel, idx);
      chk("select moved base", 32'h1, 32'(sel));
      host.io_cycle(1'b0, 10'h229, 16'h0, sel, idx);
      chk("select old base", 32'h0, 32'(sel));
      // dma channels, interrupt lines, input configuration
      dma_event <= 1'b1;
      irq_event <= 1'b1;
      input_config_jumper <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         dma_select_jumper_a <= (k == 2);
         dma_select_jumper_b <= (k == 1);
         repeat (2) @(posedge mclk);
         chk("dma line", 32'h1 << k, 32'(dma_req_q));
      end
      chk("differential mode", 32'h1, 32'(differential_mode_q));
      for (int k = 0; k < 8; k++) begin
         irq_line_jumper <= 8'h01 << k;
         repeat (2) @(posedge mclk);
         chk("irq line", 32'h1 << k, 32'(irq_line_q));
      end
      irq_event <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("irq idle", 32'h0, 32'(irq_line_q));
      // timers: reload 4 / 2 / 3, all enabled
      axi_write(`OFF_DAC0, 32'h4);
      axi_read(`OFF_DAC0);
      chk("timer0 count loaded", 32'h4, rd);
      axi_write(`OFF_DAC1, 32'h00030002);
      axi_write(`OFF_CTRL, 32'he);
      meas(2, 3 * `REF_DIV);
      meas(1, 2 * 3 * `REF_DIV);
      meas(0, 4 * `REF_DIV);
      timer0_internal_clock_sel <= 1'b0;
      timer0_external_clock_sel <= 1'b1;
      ext_run = 1'b1;
      meas(0, 4 * 8);
      results;
   end
endmodule // tb_card_cfg
